// [fpbc_pkg.sv]
package fpbc_pkg;

  // Clock rate of the block.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // Times as specified, in their own units.
  localparam int unsigned DEBOUNCE_MS = 50;
  localparam int unsigned DIAG_PULSE_MS = 30;
  localparam int unsigned WIPE_HOLD_S = 4;
  localparam int unsigned OVERRIDE_S = 4;
  localparam int unsigned BEEP_MS = 100;

  // Derived cycle counts; all divide exactly at this clock rate.
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned DIAG_PULSE_CYC = DIAG_PULSE_MS * CYC_PER_MS;
  localparam int unsigned WIPE_HOLD_CYC = WIPE_HOLD_S * CLK_HZ;
  localparam int unsigned OVERRIDE_CYC = OVERRIDE_S * CLK_HZ;
  localparam int unsigned BEEP_CYC = BEEP_MS * CYC_PER_MS;

  // Button positions within the button vector.
  localparam int unsigned NUM_BTN = 5;
  localparam int unsigned BTN_POWER = 0;
  localparam int unsigned BTN_SLEEP = 1;
  localparam int unsigned BTN_RESET = 2;
  localparam int unsigned BTN_DIAG = 3;
  localparam int unsigned BTN_ID = 4;

  // Message flag and interrupt-source bit positions, sensor offsets.
  localparam int unsigned DIAG_FLAG_BIT = 6;
  localparam int unsigned DIAG_SRC_BIT = 0;
  localparam logic [7:0] CRIT_DIAG_OFFSET = 8'h00;
  localparam logic [7:0] VIOL_ATTEMPT_OFFSET = 8'h00;

  // Values after reset.
  localparam logic RST_INT_EN = 1'b1;
  localparam logic RST_WIPE_EN = 1'b0;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // Fault tracking geometry.
  localparam int unsigned FAULT_SRCS = 4;
  localparam int unsigned FAULT_TYPES = 4;
  localparam int unsigned FAULT_W = 4;

  // Host sleep state as seen by the block.
  typedef enum logic [1:0] {
    FPBC_S0,
    FPBC_S1,
    FPBC_S45
  } fpbc_sleep_t;

  // System power and reset status levels.
  typedef struct packed {
    logic standby_power;
    logic sys_power_on;
    logic sys_reset;
    fpbc_sleep_t sleep;
  } fpbc_sys_t;

  // Firmware commands: each strobe is one cycle wide with its data.
  typedef struct packed {
    logic flags_clear;
    logic [7:0] flags_clear_mask;
    logic read_diag_source;
    logic int_en_wr;
    logic int_en;
    logic lock_wr;
    logic lock_enable;
    logic force_lock;
    logic [NUM_BTN-1:0] block_mask;
    logic wipe_wr;
    logic wipe_enable;
    logic wipe_force_off;
    logic fault_wr;
    logic [1:0] fault_src;
    logic [1:0] fault_type;
    logic [FAULT_W-1:0] fault_state;
  } fpbc_cmd_t;

  // One sensor event announcement.
  typedef struct packed {
    logic valid;
    logic [7:0] offset;
  } fpbc_event_t;

  // Button actions passed on to power control, one-cycle pulses.
  typedef struct packed {
    logic power;
    logic sleep;
    logic reset;
    logic id;
    logic force_off;
    logic power_up;
  } fpbc_act_t;

endpackage : fpbc_pkg

// [fpbc_hold.sv]
`timescale 1ns/1ns
// Reports once its run input has stayed high for CYCLES clock cycles.
module fpbc_hold #(
  parameter int unsigned CYCLES = 16
) (
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Condition and result.
  input wire logic run,
  output logic reached
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic reached;
  } fpbc_hold_st_t;

  fpbc_hold_st_t st_q;
  fpbc_hold_st_t st_d;

  generate
    if (CYCLES < 1) begin : g_bad
      $error("fpbc_hold needs CYCLES of at least one");
    end
  endgenerate

  // Any drop of run restarts the count, so only a continuous level counts.
  always_comb begin
    st_d = st_q;
    if (!run) begin
      st_d.cnt = '0;
      st_d.reached = 1'b0;
    end else if (st_q.cnt != CW'(CYCLES)) begin
      st_d.cnt = st_q.cnt + CW'(1);
      st_d.reached = (st_q.cnt + CW'(1)) == CW'(CYCLES);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign reached = st_q.reached;

endmodule : fpbc_hold

// [fpbc_pulse.sv]
`timescale 1ns/1ns
// Drives out high for exactly CYCLES cycles after a start strobe.
module fpbc_pulse #(
  parameter int unsigned CYCLES = 16
) (
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Trigger and pulse.
  input wire logic start,
  output logic out
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] left;
    logic out;
  } fpbc_pulse_st_t;

  fpbc_pulse_st_t st_q;
  fpbc_pulse_st_t st_d;

  generate
    if (CYCLES < 1) begin : g_bad
      $error("fpbc_pulse needs CYCLES of at least one");
    end
  endgenerate

  // A start during a running pulse is ignored; length never depends on the cause.
  always_comb begin
    st_d = st_q;
    if (st_q.out) begin
      st_d.left = st_q.left - CW'(1);
      st_d.out = st_q.left != CW'(1);
    end else if (start) begin
      st_d.left = CW'(CYCLES);
      st_d.out = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign out = st_q.out;

endmodule : fpbc_pulse

// [fpbc_top.sv]
`timescale 1ns/1ns
// Summary of operation
// - Diag press sends a critical event at offset 00h when events are enabled.
// - Diag press sets message flag 40h; firmware reads it and clears it.
// - Diag press sets bit 0 of the first interrupt-source byte.
// - Diag press gives a host interrupt pulse of fixed length.
// - After one pulse, no more until system reset, power-down or an enabling int_en write.
// - System reset or own reset clears the flag and all source bits.
// - Lock mode never blocks diag; only its own block bit does.
// - A wipe enable bit, set by command, gates the wipe sequence.
// - Wipe sequence is seen only with standby on, system off, enabled.
// - A valid wipe sequence sounds exactly one beep.
// - A valid wipe sets the wipe state output and powers the system up.
// - Wipe state ends on force-off, reset press, power press-release, power-off.
// - Lock mode is enabled by command; its activity follows the keyboard lock or the force-lock bit.
// - Active lock turns a protected press into a violation event at 00h.
// - Lock settings clear on AC up, system up, system reset, own reset.
// - Block bits stop single switches whether lock is active or not.
// - Protection by sleep state: S0 power/sleep/reset, S1 reset, S4/S5 none.
// - In S1 with lock, power wakes but the 4 s force-off is suppressed.
// - Fault states are kept per source and type, replaced, cleared on power-up.
// - A button counts as pressed after 50 ms of continuous low.
// - Every host interrupt pulse lasts at least 30 ms.
// - Enabling interrupt generation by command re-arms the one-shot.
module fpbc_top #(
  parameter int unsigned DEBOUNCE_CYCLES = fpbc_pkg::DEBOUNCE_CYC,
  parameter int unsigned DIAG_PULSE_CYCLES = fpbc_pkg::DIAG_PULSE_CYC,
  parameter int unsigned WIPE_HOLD_CYCLES = fpbc_pkg::WIPE_HOLD_CYC,
  parameter int unsigned OVERRIDE_CYCLES = fpbc_pkg::OVERRIDE_CYC,
  parameter int unsigned BEEP_CYCLES = fpbc_pkg::BEEP_CYC
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Front panel buttons, low while pressed.
  input wire logic [fpbc_pkg::NUM_BTN-1:0] btn_n,
  // Keyboard controller lock level.
  input wire logic keyboard_lock_input,
  // System power, reset and sleep status.
  input wire fpbc_pkg::fpbc_sys_t sys,
  // Event generation enable for the diagnostic sensor.
  input wire logic diag_event_en,
  // Firmware command strobes.
  input wire fpbc_pkg::fpbc_cmd_t cmd,
  // Host signals.
  output logic diag_interrupt_pulse,
  output logic settings_wipe_state,
  output logic speaker_beep,
  // Sensor events.
  output fpbc_pkg::fpbc_event_t crit_event,
  output fpbc_pkg::fpbc_event_t viol_event,
  // Button actions towards power control.
  output fpbc_pkg::fpbc_act_t act,
  // Status readback.
  output logic [7:0] msg_flags,
  output logic [7:0] diag_source,
  output logic [7:0] diag_source_rd,
  output logic lock_active,
  output logic [fpbc_pkg::FAULT_TYPES-1:0] fault_any
);

  localparam int unsigned NB = fpbc_pkg::NUM_BTN;
  localparam int unsigned NS = fpbc_pkg::FAULT_SRCS;
  localparam int unsigned NT = fpbc_pkg::FAULT_TYPES;
  localparam int unsigned FW = fpbc_pkg::FAULT_W;

  typedef enum logic [1:0] {
    W_IDLE,
    W_RST_HELD,
    W_BOTH
  } fpbc_wipe_st_t;

  typedef struct packed {
    logic [NB-1:0] btn_prev;
    logic pwr_prev;
    logic stby_prev;
    logic ovr_prev;
    logic [7:0] flags;
    logic [7:0] src;
    logic [7:0] src_rd;
    logic int_en;
    logic armed;
    logic lock_en;
    logic force_lock;
    logic [NB-1:0] block_mask;
    logic lock_active;
    logic wipe_en;
    logic wipe_state;
    fpbc_wipe_st_t wipe_fsm;
    logic pulse_start;
    logic beep_start;
    fpbc_pkg::fpbc_event_t crit;
    fpbc_pkg::fpbc_event_t viol;
    fpbc_pkg::fpbc_act_t act;
    logic [NS-1:0][NT-1:0][FW-1:0] faults;
    logic [NT-1:0] fault_any;
  } fpbc_state_t;

  fpbc_state_t st_q;
  fpbc_state_t st_d;

  logic [NB-1:0] btn;
  logic wipe_hold_done;
  logic ovr_hold_done;
  logic diag_pulse_out;
  logic beep_out;

  if (NS != 4 || NT != 4) begin : g_bad_fault
    $error("fault source and type selects are two bits wide");
  end

  // Each button is debounced by its own low-level hold counter; its saturation is the level.
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_deb
      fpbc_hold #(.CYCLES(DEBOUNCE_CYCLES)) u_deb (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .run(!btn_n[gi]),
        .reached(btn[gi])
      );
    end
  endgenerate

  // Reset must stay held for the full wipe hold time while the sequence is allowed.
  fpbc_hold #(.CYCLES(WIPE_HOLD_CYCLES)) u_wipe_hold (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .run(st_q.wipe_fsm == W_RST_HELD && btn[fpbc_pkg::BTN_RESET]),
    .reached(wipe_hold_done)
  );

  // Power held long enough asks for a forced power-off.
  fpbc_hold #(.CYCLES(OVERRIDE_CYCLES)) u_ovr_hold (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .run(btn[fpbc_pkg::BTN_POWER]),
    .reached(ovr_hold_done)
  );

  // Host interrupt pulse of fixed length, whatever the button does meanwhile.
  fpbc_pulse #(.CYCLES(DIAG_PULSE_CYCLES)) u_diag_pulse (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(st_q.pulse_start),
    .out(diag_pulse_out)
  );

  // Single confirmation beep.
  fpbc_pulse #(.CYCLES(BEEP_CYCLES)) u_beep (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(st_q.beep_start),
    .out(beep_out)
  );

  // Main next-state logic; every hardware set except the one-shot re-arm is applied after clears so it wins.
  always_comb begin
    logic [NB-1:0] press;
    logic [NB-1:0] release_;
    logic [NB-1:0] protect;
    logic pwr_up;
    logic pwr_down;
    logic ac_up;
    logic wipe_ok;
    logic wipe_fire;
    logic diag_ok;
    press = btn & ~st_q.btn_prev;
    release_ = ~btn & st_q.btn_prev;
    protect = '0;
    pwr_up = sys.sys_power_on && !st_q.pwr_prev;
    pwr_down = !sys.sys_power_on && st_q.pwr_prev;
    ac_up = sys.standby_power && !st_q.stby_prev;
    wipe_ok = sys.standby_power && !sys.sys_power_on && st_q.wipe_en;
    wipe_fire = 1'b0;
    diag_ok = press[fpbc_pkg::BTN_DIAG] && !st_q.block_mask[fpbc_pkg::BTN_DIAG];
    st_d = st_q;
    st_d.btn_prev = btn;
    st_d.pwr_prev = sys.sys_power_on;
    st_d.stby_prev = sys.standby_power;
    st_d.ovr_prev = ovr_hold_done;
    st_d.pulse_start = 1'b0;
    st_d.beep_start = 1'b0;
    st_d.crit = '0;
    st_d.viol = '0;
    st_d.act = '0;
    // Firmware writes of the lock options.
    if (cmd.lock_wr) begin
      st_d.lock_en = cmd.lock_enable;
      st_d.force_lock = cmd.force_lock;
      st_d.block_mask = cmd.block_mask;
    end
    // Power and reset events wipe the lock settings.
    if (ac_up || pwr_up || sys.sys_reset) begin
      st_d.lock_en = 1'b0;
      st_d.force_lock = 1'b0;
      st_d.block_mask = '0;
    end
    st_d.lock_active = st_d.lock_en && (keyboard_lock_input || st_d.force_lock);
    // The diagnostic and identify switches are never protected by lock mode.
    if (st_q.lock_active) begin
      case (sys.sleep)
        fpbc_pkg::FPBC_S0: begin
          protect[fpbc_pkg::BTN_POWER] = 1'b1;
          protect[fpbc_pkg::BTN_SLEEP] = 1'b1;
          protect[fpbc_pkg::BTN_RESET] = 1'b1;
        end
        fpbc_pkg::FPBC_S1: begin
          protect[fpbc_pkg::BTN_RESET] = 1'b1;
        end
        default: begin
          protect = '0;
        end
      endcase
    end
    // Ordinary button actions are held back while a wipe sequence is in progress.
    if (st_q.wipe_fsm == W_IDLE) begin
      for (int i = 0; i < NB; i++) begin
        if (press[i] && !st_q.block_mask[i] && protect[i]) begin
          st_d.viol.valid = 1'b1;
          st_d.viol.offset = fpbc_pkg::VIOL_ATTEMPT_OFFSET;
        end
      end
      st_d.act.power = press[fpbc_pkg::BTN_POWER] && !st_q.block_mask[fpbc_pkg::BTN_POWER]
        && !protect[fpbc_pkg::BTN_POWER];
      st_d.act.sleep = press[fpbc_pkg::BTN_SLEEP] && !st_q.block_mask[fpbc_pkg::BTN_SLEEP]
        && !protect[fpbc_pkg::BTN_SLEEP];
      st_d.act.reset = press[fpbc_pkg::BTN_RESET] && !st_q.block_mask[fpbc_pkg::BTN_RESET]
        && !protect[fpbc_pkg::BTN_RESET];
      st_d.act.id = press[fpbc_pkg::BTN_ID] && !st_q.block_mask[fpbc_pkg::BTN_ID];
      // S1 under lock still wakes on power, but the long-hold force-off is withheld.
      st_d.act.force_off = ovr_hold_done && !st_q.ovr_prev
        && !st_q.block_mask[fpbc_pkg::BTN_POWER]
        && !(st_q.lock_active && (sys.sleep == fpbc_pkg::FPBC_S0
        || sys.sleep == fpbc_pkg::FPBC_S1));
    end
    // Settings-wipe sequence: reset held, then power added, then both released.
    case (st_q.wipe_fsm)
      W_IDLE: begin
        if (wipe_ok && press[fpbc_pkg::BTN_RESET] && !btn[fpbc_pkg::BTN_POWER]) begin
          st_d.wipe_fsm = W_RST_HELD;
        end
      end
      W_RST_HELD: begin
        if (!wipe_ok || !btn[fpbc_pkg::BTN_RESET]) begin
          st_d.wipe_fsm = W_IDLE;
        end else if (press[fpbc_pkg::BTN_POWER]) begin
          st_d.wipe_fsm = wipe_hold_done ? W_BOTH : W_IDLE;
        end
      end
      W_BOTH: begin
        if (!wipe_ok) begin
          st_d.wipe_fsm = W_IDLE;
        end else if (!btn[fpbc_pkg::BTN_RESET] && !btn[fpbc_pkg::BTN_POWER]) begin
          st_d.wipe_fsm = W_IDLE;
          wipe_fire = 1'b1;
        end
      end
      default: begin
        st_d.wipe_fsm = W_IDLE;
      end
    endcase
    // Wipe enable and the wipe state itself.
    if (cmd.wipe_wr) begin
      st_d.wipe_en = cmd.wipe_enable;
      if (cmd.wipe_force_off) begin
        st_d.wipe_state = 1'b0;
      end
    end
    if (st_q.wipe_fsm == W_IDLE && (press[fpbc_pkg::BTN_RESET]
        || release_[fpbc_pkg::BTN_POWER])) begin
      st_d.wipe_state = 1'b0;
    end
    if (pwr_down) begin
      st_d.wipe_state = 1'b0;
    end
    if (wipe_fire) begin
      st_d.wipe_state = 1'b1;
      st_d.act.power_up = 1'b1;
      st_d.beep_start = 1'b1;
    end
    // Interrupt generation enable; every enabling write re-arms the one-shot.
    if (cmd.int_en_wr) begin
      st_d.int_en = cmd.int_en;
      st_d.armed = st_q.armed || cmd.int_en;
    end
    if (sys.sys_reset || pwr_down) begin
      st_d.armed = 1'b1;
    end
    // Firmware clears of the flags and the source byte; reading the source clears it.
    if (cmd.flags_clear) begin
      st_d.flags = st_q.flags & ~cmd.flags_clear_mask;
    end
    if (cmd.read_diag_source) begin
      st_d.src_rd = st_q.src;
      st_d.src = '0;
    end
    if (sys.sys_reset) begin
      st_d.flags = '0;
      st_d.src = '0;
    end
    // Diagnostic button press: flag, source, event, and one pulse if armed.
    if (diag_ok) begin
      st_d.flags[fpbc_pkg::DIAG_FLAG_BIT] = 1'b1;
      st_d.src[fpbc_pkg::DIAG_SRC_BIT] = 1'b1;
      if (diag_event_en) begin
        st_d.crit.valid = 1'b1;
        st_d.crit.offset = fpbc_pkg::CRIT_DIAG_OFFSET;
      end
      if (st_q.armed && st_q.int_en && !diag_pulse_out) begin
        st_d.pulse_start = 1'b1;
        st_d.armed = 1'b0;
      end
    end
    // Fault states: each write replaces one source and type entry.
    if (cmd.fault_wr) begin
      st_d.faults[cmd.fault_src][cmd.fault_type] = cmd.fault_state;
    end
    if (pwr_up || sys.sys_reset) begin
      st_d.faults = '0;
    end
    for (int t = 0; t < NT; t++) begin
      st_d.fault_any[t] = 1'b0;
      for (int s = 0; s < NS; s++) begin
        st_d.fault_any[t] = st_d.fault_any[t] || (st_d.faults[s][t] != '0);
      end
    end
  end

  // Register stage; own reset restores every setting.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.flags <= fpbc_pkg::RST_FLAGS;
      st_q.int_en <= fpbc_pkg::RST_INT_EN;
      st_q.armed <= 1'b1;
      st_q.wipe_en <= fpbc_pkg::RST_WIPE_EN;
      st_q.wipe_fsm <= W_IDLE;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from flip-flops here or in the pulse modules.
  assign diag_interrupt_pulse = diag_pulse_out;
  assign speaker_beep = beep_out;
  assign settings_wipe_state = st_q.wipe_state;
  assign crit_event = st_q.crit;
  assign viol_event = st_q.viol;
  assign act = st_q.act;
  assign msg_flags = st_q.flags;
  assign diag_source = st_q.src;
  assign diag_source_rd = st_q.src_rd;
  assign lock_active = st_q.lock_active;
  assign fault_any = st_q.fault_any;

endmodule : fpbc_top

// [fpbc_panel.sv]
`timescale 1ns/1ns
// Front panel contacts with pull-ups: an open contact reads high.
module fpbc_panel (
  // Clock and operator hands.
  input wire logic clk,
  input wire logic [4:0] press,
  // Contact levels, low while held.
  output logic [4:0] btn_n
);
  // Contacts follow the hands one cycle late, like a real switch path.
  initial btn_n = '1;
  always @(posedge clk) btn_n <= ~press;
endmodule : fpbc_panel

// [fpbc_top_sva.sv]
`timescale 1ns/1ns
// Port relations of the button controller.
module fpbc_top_sva #(
  parameter int unsigned DIAG_PULSE_CYCLES = 5,
  parameter int unsigned BEEP_CYCLES = 6
) (
  // Clock, reset and inputs.
  input wire logic clk,
  input wire logic reset,
  input wire logic keyboard_lock_input,
  input wire fpbc_pkg::fpbc_sys_t sys,
  input wire fpbc_pkg::fpbc_cmd_t cmd,
  // Outputs.
  input wire logic diag_interrupt_pulse,
  input wire logic settings_wipe_state,
  input wire logic speaker_beep,
  input wire fpbc_pkg::fpbc_event_t crit_event,
  input wire fpbc_pkg::fpbc_event_t viol_event,
  input wire fpbc_pkg::fpbc_act_t act,
  input wire logic [7:0] msg_flags,
  input wire logic [7:0] diag_source,
  input wire logic lock_active,
  input wire logic [fpbc_pkg::FAULT_TYPES-1:0] fault_any
);
  int unsigned pulse_len_q;
  int unsigned beep_len_q;
  logic armed_q;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Run lengths are counted so that a wrong length shows where the output falls.
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_len_q <= 0;
      beep_len_q <= 0;
    end else begin
      pulse_len_q <= diag_interrupt_pulse ? pulse_len_q + 1 : 0;
      beep_len_q <= speaker_beep ? beep_len_q + 1 : 0;
    end
  end

  // Generous on purpose: anything that may re-arm the one-shot sets it.
  always_ff @(posedge clk) begin
    if (reset || sys.sys_reset || !sys.sys_power_on || (cmd.int_en_wr && cmd.int_en)) begin
      armed_q <= 1'b1;
    end else if (diag_interrupt_pulse) begin
      armed_q <= 1'b0;
    end
  end

  chk_pulse_length:
    assert property ($fell(diag_interrupt_pulse) |-> pulse_len_q == DIAG_PULSE_CYCLES)
    else $error("pulse length");
  chk_beep_length:
    assert property ($fell(speaker_beep) |-> beep_len_q == BEEP_CYCLES) else $error("beep length");
  chk_one_shot:
    assert property ($rose(diag_interrupt_pulse) |-> armed_q) else $error("pulse not armed");
  chk_crit_event:
    assert property (crit_event.valid |-> crit_event.offset == 8'h00 && msg_flags[6] && diag_source[0])
    else $error("critical event");
  chk_viol_event:
    assert property (viol_event.valid |-> viol_event.offset == 8'h00 && lock_active)
    else $error("violation event");
  chk_lock_rise:
    assert property ($rose(lock_active) |-> $past(cmd.lock_wr) || $past(keyboard_lock_input))
    else $error("lock rise");
  chk_sys_reset:
    assert property (sys.sys_reset |=> msg_flags[6] == 1'b0 && diag_source == 8'h00 && !lock_active
      && fault_any == '0) else $error("system reset clear");
  chk_wipe_rise:
    assert property ($rose(settings_wipe_state) |-> act.power_up ##1 speaker_beep)
    else $error("wipe start");
  chk_wipe_off:
    assert property (cmd.wipe_wr && cmd.wipe_force_off |=> !settings_wipe_state)
    else $error("wipe off");
endmodule : fpbc_top_sva

bind fpbc_top fpbc_top_sva #(
  .DIAG_PULSE_CYCLES(DIAG_PULSE_CYCLES),
  .BEEP_CYCLES(BEEP_CYCLES)
) fpbc_top_sva_inst (
  .clk, .reset, .keyboard_lock_input, .sys, .cmd, .diag_interrupt_pulse,
  .settings_wipe_state, .speaker_beep, .crit_event, .viol_event, .act,
  .msg_flags, .diag_source, .lock_active, .fault_any
);

// [fpbc_top_tb.sv]
`timescale 1ns/1ns
// Self-checking bench for the button controller.
module fpbc_top_tb;
  localparam int DB = 4;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic kb = 1'b0;
  logic ev_en = 1'b1;
  logic [4:0] press = '0;
  logic [4:0] btn_n;
  fpbc_pkg::fpbc_sys_t sys = '{1'b1, 1'b1, 1'b0, fpbc_pkg::FPBC_S0};
  fpbc_pkg::fpbc_cmd_t cmd = '0;
  fpbc_pkg::fpbc_cmd_t c;
  fpbc_pkg::fpbc_event_t crit, viol;
  fpbc_pkg::fpbc_act_t act, s_act;
  logic pulse, wipe, beep, lock, s_crit, s_viol, s_pulse, s_wipe, s_beep;
  logic [7:0] flags, src, src_rd;
  logic [3:0] fault;
  int fail_count = 0;
  int checks = 0;

  initial forever #4 clk = ~clk;

  // Short counts keep the run brief; every expectation uses these values.
  fpbc_panel fpbc_panel_inst (.clk, .press, .btn_n);
  fpbc_top #(.DEBOUNCE_CYCLES(DB), .DIAG_PULSE_CYCLES(5), .WIPE_HOLD_CYCLES(HOLD),
    .OVERRIDE_CYCLES(20), .BEEP_CYCLES(6)) fpbc_top_inst (.clk, .reset, .clk_en(1'b1),
    .btn_n, .keyboard_lock_input(kb), .sys, .diag_event_en(ev_en), .cmd,
    .diag_interrupt_pulse(pulse), .settings_wipe_state(wipe), .speaker_beep(beep),
    .crit_event(crit), .viol_event(viol), .act, .msg_flags(flags), .diag_source(src),
    .diag_source_rd(src_rd), .lock_active(lock), .fault_any(fault));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // Commands are one-cycle strobes; the result is looked at after the next edge.
  task automatic send();
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= '0;
    @(negedge clk);
  endtask : send

  // Collects every one-cycle output seen over a window.
  task automatic watch(input int n);
    {s_crit, s_viol, s_pulse, s_wipe, s_beep} = '0;
    s_act = '0;
    repeat (n) begin
      @(negedge clk);
      {s_crit, s_viol, s_pulse, s_wipe, s_beep} |= {crit.valid, viol.valid, pulse, wipe, beep};
      s_act = s_act | act;
    end
  endtask : watch

  task automatic push(input int b, input int hold, input int n);
    fork
      begin
        @(posedge clk) press[b] <= 1'b1;
        repeat (hold) @(posedge clk);
        press[b] <= 1'b0;
      end
      watch(n);
    join
  endtask : push

  task automatic sys_rst();
    @(posedge clk) sys.sys_reset <= 1'b1;
    @(posedge clk) sys.sys_reset <= 1'b0;
    @(negedge clk);
  endtask : sys_rst

  task automatic t_diag();
    push(3, 8, 20);
    check("crit", s_crit, 1);
    check("pulse", s_pulse, 1);
    check("flags", flags, 8'h40);
    check("src", src, 8'h01);
    c = '0;
    c.read_diag_source = 1'b1;
    c.flags_clear = 1'b1;
    c.flags_clear_mask = 8'h40;
    send();
    check("src_rd", src_rd, 8'h01);
    check("cleared", flags | src, 8'h00);
    @(posedge clk) ev_en <= 1'b0;
    push(3, 8, 20);
    check("crit_off", s_crit, 0);
    check("one_shot", s_pulse, 0);
    c = '0;
    c.int_en_wr = 1'b1;
    c.int_en = 1'b1;
    send();
    push(3, 8, 20);
    check("rearm", s_pulse, 1);
    sys_rst();
    check("sys_reset", flags | src, 8'h00);
  endtask : t_diag

  // The boundary of the debounce count, then a switch blocked by its own bit.
  task automatic t_debounce_block();
    push(3, DB - 1, 14);
    check("short", flags, 8'h00);
    push(3, DB, 14);
    check("long", flags, 8'h40);
    c = '0;
    c.flags_clear = 1'b1;
    c.flags_clear_mask = 8'h40;
    send();
    c = '0;
    c.lock_wr = 1'b1;
    c.block_mask = 5'h08;
    send();
    push(3, 8, 20);
    check("blocked", flags, 8'h00);
  endtask : t_debounce_block

  task automatic t_lock();
    int prot;
    c = '0;
    c.lock_wr = 1'b1;
    c.lock_enable = 1'b1;
    c.force_lock = 1'b1;
    send();
    check("forced", lock, 1);
    sys_rst();
    check("lock_clr", lock, 0);
    c.force_lock = 1'b0;
    send();
    @(posedge clk) kb <= 1'b1;
    repeat (2) @(negedge clk);
    check("kb_lock", lock, 1);
    for (int s = 0; s < 3; s++) begin
      @(posedge clk) sys.sleep <= fpbc_pkg::fpbc_sleep_t'(s);
      for (int b = 0; b < 5; b++) begin
        prot = (s == 0 && b < 3) || (s == 1 && b == 2);
        push(b, 8, 20);
        check("viol", s_viol, prot);
        check("acted", b == 3 ? flags[6] : s_act[5 - b + (b == 4)], !prot);
      end
    end
    push(0, 30, 40);
    check("force_off", s_act.force_off, 1);
    @(posedge clk) sys.sleep <= fpbc_pkg::FPBC_S1;
    push(0, 30, 40);
    check("no_force_off", s_act.force_off, 0);
  endtask : t_lock

  task automatic t_fault();
    c = '0;
    c.fault_wr = 1'b1;
    c.fault_src = 2'h1;
    c.fault_type = 2'h2;
    c.fault_state = 4'h3;
    send();
    c.fault_src = 2'h2;
    c.fault_state = 4'h1;
    send();
    c.fault_src = 2'h1;
    c.fault_state = 4'h0;
    send();
    check("fault", fault, 8'h04);
  endtask : t_fault

  // Only the last pass has the feature enabled with system power off.
  task automatic t_wipe();
    for (int k = 0; k < 3; k++) begin
      c = '0;
      c.wipe_wr = 1'b1;
      c.wipe_enable = (k != 0);
      send();
      @(posedge clk) sys.sys_power_on <= (k == 1);
      press[2] <= 1'b1;
      repeat (DB + HOLD + 4) @(posedge clk);
      press[0] <= 1'b1;
      repeat (8) @(posedge clk);
      press <= '0;
      watch(24);
      check("wipe", s_wipe, k == 2);
      check("beep", s_beep, k == 2);
      check("power_up", s_act.power_up, k == 2);
    end
    c = '0;
    c.wipe_wr = 1'b1;
    c.wipe_force_off = 1'b1;
    send();
    check("wipe_off", wipe, 0);
  endtask : t_wipe

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check("reset", flags | src | {5'h0, pulse, wipe, lock}, 8'h00);
    t_diag();
    t_debounce_block();
    t_lock();
    t_fault();
    t_wipe();
    close_out();
  end
endmodule : fpbc_top_tb
